// File: dpg_gpio_map.svh
/*
  Register offsets, bit positions and reset values for the dual GPIO port.
  Assumes a 32-bit APB master and a single system clock.
*/
// How it works
// - Pin driver enable always follows the direction bit, whatever the function select.
// - Every bit of both ports has its own full set of control bits.
// - Port one bit 0 in module mode drives low, feeds timer external clock.
// - Port one bits 1-3 output timer channels 0-2, feed capture A inputs.
// - Port one bit 4 outputs sub-main clock, bits 5-7 timer channels 0-2.
// - Port two bit 0 in module mode outputs the auxiliary clock.
// - Port two bit 1 in module mode drives low, feeds timer alternate clock.
// - Port two bit 2 outputs comparator result, feeds capture 0 B input.
// - Port two bits 3 and 4 output timer channels 1 and 2.
// - Port two bit 5 in module mode drives low.
// - Port two bits 6-7 have no pin but keep all their register bits.
// - Port two flags 6-7 change only by software and raise interrupts.
`ifndef DPG_GPIO_MAP_SVH
`define DPG_GPIO_MAP_SVH
// Word fields within a port block (paddr[4:2])
`define DPG_REG_IN   3'h0
`define DPG_REG_OUT  3'h1
`define DPG_REG_DIR  3'h2
`define DPG_REG_IFG  3'h3
`define DPG_REG_IES  3'h4
`define DPG_REG_IE   3'h5
`define DPG_REG_SEL  3'h6
`define DPG_REG_SET  3'h7
// Address decode
`define DPG_ADDR_HI  6'h00
`define DPG_ADDR_LO  2'h0
`define DPG_PORT_BIT 5
`define DPG_RST8     8'h00
`define DPG_P2_PINS  8'h3f
`define DPG_P1       0
`define DPG_P2       1
// Port one module bits
`define DPG_P1_TCLK  0
`define DPG_P1_CAP0  1
`define DPG_P1_CAP1  2
`define DPG_P1_CAP2  3
`define DPG_P1_SUBMAIN_SYSTEM_CLOCK 4
`define DPG_P1_T0    5
`define DPG_P1_T1    6
`define DPG_P1_T2    7
// Port two module bits
`define DPG_P2_ACLK  0
`define DPG_P2_ALT   1
`define DPG_P2_COMP  2
`define DPG_P2_T1    3
`define DPG_P2_T2    4
`define DPG_P2_LOW   5
`define DPG_P2_SW    7:6
`endif

// File: dpg_pkg.sv
/*
  Shared types for the dual GPIO port.
  Assumes dpg_gpio_map.svh supplies the constants.
*/
package dpg_pkg;
  typedef logic [7:0]  dpg_byte_type;
  typedef logic [11:0] dpg_addr_type;
endpackage : dpg_pkg

// File: dpg_ports.sv
/*
  Two 8-bit GPIO ports with function select, edge interrupts and APB access.
  Assumes pins are asynchronous; module signals share clk_in.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "dpg_gpio_map.svh"

module dpg_ports (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Port one pins
  input  wire logic [7:0]  port_one_pad_in,
  output logic      [7:0]  port_one_pad_out,
  output logic      [7:0]  port_one_pad_oe_out,
  // Port two pins
  input  wire logic [5:0]  port_two_pad_in,
  output logic      [5:0]  port_two_pad_out,
  output logic      [5:0]  port_two_pad_oe_out,
  // Module signals to pins
  input  wire logic        timer_channel0_output_in,
  input  wire logic        timer_channel1_output_in,
  input  wire logic        timer_channel2_output_in,
  input  wire logic        submain_system_clock_in,
  input  wire logic        auxiliary_clock_in,
  input  wire logic        comparator_result_out_in,
  // Pins to modules
  output logic             timer_external_clock_in_out,
  output logic             timer_alternate_clock_in_out,
  output logic             capture0_input_a_out,
  output logic             capture1_input_a_out,
  output logic             capture2_input_a_out,
  output logic             capture0_input_b_out,
  // Interrupt
  output logic             irq_out
);

  dpg_pkg::dpg_byte_type sel_q [2];
  dpg_pkg::dpg_byte_type sel_d [2];
  dpg_pkg::dpg_byte_type dir_q [2];
  dpg_pkg::dpg_byte_type dir_d [2];
  dpg_pkg::dpg_byte_type out_q [2];
  dpg_pkg::dpg_byte_type out_d [2];
  dpg_pkg::dpg_byte_type ie_q  [2];
  dpg_pkg::dpg_byte_type ie_d  [2];
  dpg_pkg::dpg_byte_type ies_q [2];
  dpg_pkg::dpg_byte_type ies_d [2];
  dpg_pkg::dpg_byte_type ifg_q [2];
  dpg_pkg::dpg_byte_type ifg_d [2];
  dpg_pkg::dpg_byte_type s1_q  [2];
  dpg_pkg::dpg_byte_type s2_q  [2];
  dpg_pkg::dpg_byte_type prv_q [2];
  dpg_pkg::dpg_byte_type pin_v [2];
  dpg_pkg::dpg_byte_type ev    [2];
  dpg_pkg::dpg_byte_type mod_v [2];
  dpg_pkg::dpg_byte_type wd;
  logic        hit;
  logic        wr_en;
  logic        wport;
  logic [2:0]  field;
  logic        pready_d;
  logic        pslverr_d;
  logic [31:0] prdata_d;
  logic [7:0]  p1_pad_d;
  logic [5:0]  p2_pad_d;
  logic [5:0]  tap_d;
  logic        irq_d;

  function automatic logic dpg_decode(input dpg_pkg::dpg_addr_type a);
    return (a[11:6] == `DPG_ADDR_HI) && (a[1:0] == `DPG_ADDR_LO);
  endfunction : dpg_decode

  // Pin synchronisers and edge history
  assign pin_v[`DPG_P1] = port_one_pad_in;
  assign pin_v[`DPG_P2] = {2'h0, port_two_pad_in};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < 2; p++) begin
        s1_q[p]  <= `DPG_RST8;
        s2_q[p]  <= `DPG_RST8;
        prv_q[p] <= `DPG_RST8;
      end
    end else if (ce_in) begin
      for (int p = 0; p < 2; p++) begin
        s1_q[p]  <= pin_v[p];
        s2_q[p]  <= s1_q[p];
        prv_q[p] <= s2_q[p];
      end
    end
  end

  // Edge events per port
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_edge
      dpg_pkg::dpg_byte_type pins;
      assign pins = (g == `DPG_P2) ? `DPG_P2_PINS : 8'hff;
      assign ev[g] = pins & ((ies_q[g] & prv_q[g] & ~s2_q[g]) |
                             (~ies_q[g] & s2_q[g] & ~prv_q[g]));
    end
  endgenerate

  // APB decode
  assign hit   = dpg_decode(paddr_in);
  assign field = paddr_in[4:2];
  assign wport = paddr_in[`DPG_PORT_BIT];
  assign wd    = pwdata_in[7:0];
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in && hit;

  always_comb begin
    pready_d  = psel_in && penable_in && !pready_out;
    pslverr_d = pready_d && !hit;
    prdata_d  = 32'h0;
    if (pready_d && hit && !pwrite_in) begin
      unique case (field)
        `DPG_REG_IN:  prdata_d[7:0] = wport ? (s2_q[`DPG_P2] & `DPG_P2_PINS)
                                            : s2_q[`DPG_P1];
        `DPG_REG_OUT: prdata_d[7:0] = out_q[wport];
        `DPG_REG_DIR: prdata_d[7:0] = dir_q[wport];
        `DPG_REG_IFG: prdata_d[7:0] = ifg_q[wport];
        `DPG_REG_IES: prdata_d[7:0] = ies_q[wport];
        `DPG_REG_IE:  prdata_d[7:0] = ie_q[wport];
        `DPG_REG_SEL: prdata_d[7:0] = sel_q[wport];
        `DPG_REG_SET: prdata_d[7:0] = `DPG_RST8;
      endcase
    end
  end

  // Control registers, per-bit for both ports
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      sel_d[p] = sel_q[p];
      dir_d[p] = dir_q[p];
      out_d[p] = out_q[p];
      ie_d[p]  = ie_q[p];
      ies_d[p] = ies_q[p];
      ifg_d[p] = ifg_q[p];
      if (wr_en && (wport == p[0])) begin
        unique case (field)
          `DPG_REG_IN:  ;
          `DPG_REG_OUT: out_d[p] = wd;
          `DPG_REG_DIR: dir_d[p] = wd;
          `DPG_REG_IFG: ifg_d[p] = ifg_q[p] & ~wd;
          `DPG_REG_IES: ies_d[p] = wd;
          `DPG_REG_IE:  ie_d[p]  = wd;
          `DPG_REG_SEL: sel_d[p] = wd;
          `DPG_REG_SET: ifg_d[p] = ifg_q[p] | wd;
        endcase
      end
      ifg_d[p] = ifg_d[p] | ev[p];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < 2; p++) begin
        sel_q[p] <= `DPG_RST8;
        dir_q[p] <= `DPG_RST8;
        out_q[p] <= `DPG_RST8;
        ie_q[p]  <= `DPG_RST8;
        ies_q[p] <= `DPG_RST8;
        ifg_q[p] <= `DPG_RST8;
      end
    end else if (ce_in) begin
      for (int p = 0; p < 2; p++) begin
        sel_q[p] <= sel_d[p];
        dir_q[p] <= dir_d[p];
        out_q[p] <= out_d[p];
        ie_q[p]  <= ie_d[p];
        ies_q[p] <= ies_d[p];
        ifg_q[p] <= ifg_d[p];
      end
    end
  end

  // Module output values per bit
  always_comb begin
    mod_v[`DPG_P1] = `DPG_RST8;
    mod_v[`DPG_P2] = `DPG_RST8;
    mod_v[`DPG_P1][`DPG_P1_TCLK]  = 1'b0;
    mod_v[`DPG_P1][`DPG_P1_CAP0]  = timer_channel0_output_in;
    mod_v[`DPG_P1][`DPG_P1_CAP1]  = timer_channel1_output_in;
    mod_v[`DPG_P1][`DPG_P1_CAP2]  = timer_channel2_output_in;
    mod_v[`DPG_P1][`DPG_P1_SUBMAIN_SYSTEM_CLOCK] = submain_system_clock_in;
    mod_v[`DPG_P1][`DPG_P1_T0]    = timer_channel0_output_in;
    mod_v[`DPG_P1][`DPG_P1_T1]    = timer_channel1_output_in;
    mod_v[`DPG_P1][`DPG_P1_T2]    = timer_channel2_output_in;
    mod_v[`DPG_P2][`DPG_P2_ACLK]  = auxiliary_clock_in;
    mod_v[`DPG_P2][`DPG_P2_ALT]   = 1'b0;
    mod_v[`DPG_P2][`DPG_P2_COMP]  = comparator_result_out_in;
    mod_v[`DPG_P2][`DPG_P2_T1]    = timer_channel1_output_in;
    mod_v[`DPG_P2][`DPG_P2_T2]    = timer_channel2_output_in;
    p1_pad_d = (sel_q[`DPG_P1] & mod_v[`DPG_P1]) | (~sel_q[`DPG_P1] & out_q[`DPG_P1]);
    p2_pad_d = 6'((sel_q[`DPG_P2] & mod_v[`DPG_P2]) |
                  (~sel_q[`DPG_P2] & out_q[`DPG_P2]));
    tap_d[0] = sel_q[`DPG_P1][`DPG_P1_TCLK] & s2_q[`DPG_P1][`DPG_P1_TCLK];
    tap_d[1] = sel_q[`DPG_P2][`DPG_P2_ALT]  & s2_q[`DPG_P2][`DPG_P2_ALT];
    tap_d[2] = sel_q[`DPG_P1][`DPG_P1_CAP0] & s2_q[`DPG_P1][`DPG_P1_CAP0];
    tap_d[3] = sel_q[`DPG_P1][`DPG_P1_CAP1] & s2_q[`DPG_P1][`DPG_P1_CAP1];
    tap_d[4] = sel_q[`DPG_P1][`DPG_P1_CAP2] & s2_q[`DPG_P1][`DPG_P1_CAP2];
    tap_d[5] = sel_q[`DPG_P2][`DPG_P2_COMP] & s2_q[`DPG_P2][`DPG_P2_COMP];
    irq_d = |((ifg_q[`DPG_P1] & ie_q[`DPG_P1]) | (ifg_q[`DPG_P2] & ie_q[`DPG_P2]));
  end

  // Registered outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out                   <= 32'h0;
      pready_out                   <= 1'b0;
      pslverr_out                  <= 1'b0;
      port_one_pad_out             <= `DPG_RST8;
      port_one_pad_oe_out          <= `DPG_RST8;
      port_two_pad_out             <= 6'h0;
      port_two_pad_oe_out          <= 6'h0;
      timer_external_clock_in_out  <= 1'b0;
      timer_alternate_clock_in_out <= 1'b0;
      capture0_input_a_out         <= 1'b0;
      capture1_input_a_out         <= 1'b0;
      capture2_input_a_out         <= 1'b0;
      capture0_input_b_out         <= 1'b0;
      irq_out                      <= 1'b0;
    end else if (ce_in) begin
      prdata_out                   <= prdata_d;
      pready_out                   <= pready_d;
      pslverr_out                  <= pslverr_d;
      port_one_pad_out             <= p1_pad_d;
      port_one_pad_oe_out          <= dir_q[`DPG_P1];
      port_two_pad_out             <= p2_pad_d;
      port_two_pad_oe_out          <= dir_q[`DPG_P2][5:0];
      timer_external_clock_in_out  <= tap_d[0];
      timer_alternate_clock_in_out <= tap_d[1];
      capture0_input_a_out         <= tap_d[2];
      capture1_input_a_out         <= tap_d[3];
      capture2_input_a_out         <= tap_d[4];
      capture0_input_b_out         <= tap_d[5];
      irq_out                      <= irq_d;
    end
  end

  // Checks
  a_oe_follows_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(ce_in) && ce_in |=> port_one_pad_oe_out == $past(dir_q[`DPG_P1]))
    else $error("pad enable differs from direction");

  a_tclk_pin_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P1][`DPG_P1_TCLK] |=>
      !port_one_pad_out[`DPG_P1_TCLK] &&
      timer_external_clock_in_out == $past(s2_q[`DPG_P1][`DPG_P1_TCLK]))
    else $error("external clock pin misrouted");

  a_cap_a_route: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P1][`DPG_P1_CAP1] |=>
      port_one_pad_out[`DPG_P1_CAP1] == $past(timer_channel1_output_in) &&
      capture1_input_a_out == $past(s2_q[`DPG_P1][`DPG_P1_CAP1]))
    else $error("capture A pin misrouted");

  a_submain_system_clock_out: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P1][`DPG_P1_SUBMAIN_SYSTEM_CLOCK] |=>
      port_one_pad_out[`DPG_P1_SUBMAIN_SYSTEM_CLOCK] == $past(submain_system_clock_in))
    else $error("sub-main clock not on pin");

  a_aclk_out: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P2][`DPG_P2_ACLK] |=>
      port_two_pad_out[`DPG_P2_ACLK] == $past(auxiliary_clock_in))
    else $error("auxiliary clock not on pin");

  a_alt_clk_route: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P2][`DPG_P2_ALT] |=>
      !port_two_pad_out[`DPG_P2_ALT] &&
      timer_alternate_clock_in_out == $past(s2_q[`DPG_P2][`DPG_P2_ALT]))
    else $error("alternate clock pin misrouted");

  a_comp_cap_b: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P2][`DPG_P2_COMP] |=>
      port_two_pad_out[`DPG_P2_COMP] == $past(comparator_result_out_in) &&
      capture0_input_b_out == $past(s2_q[`DPG_P2][`DPG_P2_COMP]))
    else $error("comparator pin misrouted");

  a_p2_timer_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sel_q[`DPG_P2][`DPG_P2_T2] && sel_q[`DPG_P2][`DPG_P2_LOW] |=>
      port_two_pad_out[`DPG_P2_T2] == $past(timer_channel2_output_in) &&
      !port_two_pad_out[`DPG_P2_LOW])
    else $error("port two module output wrong");

  a_sw_flag_only: assert property (@(posedge clk_in) disable iff (rst_in)
    !wr_en |=> ifg_q[`DPG_P2][`DPG_P2_SW] == $past(ifg_q[`DPG_P2][`DPG_P2_SW]))
    else $error("software flag changed without a write");

  a_edge_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && (ev[`DPG_P1] != `DPG_RST8) |=>
      (ifg_q[`DPG_P1] & $past(ev[`DPG_P1])) == $past(ev[`DPG_P1]))
    else $error("edge did not set flag");

  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in |=> irq_out == $past(|((ifg_q[`DPG_P1] & ie_q[`DPG_P1]) |
                                 (ifg_q[`DPG_P2] & ie_q[`DPG_P2]))))
    else $error("interrupt level differs from flags");

endmodule : dpg_ports

// File: dpg_pin_partner.sv
/*
  Far-side model: pin wires and on-chip module signals for dpg_ports.
  Assumes the bench sets external pin levels and module levels.
*/
module dpg_pin_partner (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Bench levels
  input  wire logic [13:0] ext_level_in,
  input  wire logic [5:0]  mod_level_in,
  // Design pin drivers
  input  wire logic [7:0]  p1_drive_in,
  input  wire logic [7:0]  p1_oe_in,
  input  wire logic [5:0]  p2_drive_in,
  input  wire logic [5:0]  p2_oe_in,
  // Resolved pins and module signals
  output logic      [7:0]  p1_pin_out,
  output logic      [5:0]  p2_pin_out,
  output logic      [5:0]  mod_out
);
  logic [5:0] mod_q;
  logic [5:0] mod_d;
  // Module signals launched on the shared clock
  always_comb begin
    mod_d = mod_level_in;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mod_q <= 6'h00;
    end else begin
      mod_q <= mod_d;
    end
  end
  // Driver wins where enabled, else the outside level
  assign p1_pin_out = (p1_oe_in & p1_drive_in) | (~p1_oe_in & ext_level_in[7:0]);
  assign p2_pin_out = (p2_oe_in & p2_drive_in) | (~p2_oe_in & ext_level_in[13:8]);
  assign mod_out    = mod_q;
endmodule : dpg_pin_partner

// File: dpg_ports_tb.sv
/*
  Self-checking bench for dpg_ports: APB tasks and pin scenarios.
  Assumes dpg_pin_partner models the pins and module signals.
*/
`include "dpg_gpio_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module dpg_ports_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic [7:0]  p1_pin;
  logic [7:0]  p1_drv;
  logic [7:0]  p1_oe;
  logic [5:0]  p2_pin;
  logic [5:0]  p2_drv;
  logic [5:0]  p2_oe;
  logic [5:0]  mod_sig;
  logic [5:0]  to_mod;
  logic [5:0]  mod_lvl = 6'h00;
  logic [13:0] ext_lvl = 14'h0000;
  logic        ce_lvl = 1'b1;
  int          n_fail = 0;
  int          tests_run = 0;
  dpg_ports DUT (
    .clk_in, .rst_in, .ce_in(ce_lvl),
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out,
    .port_one_pad_in(p1_pin), .port_one_pad_out(p1_drv), .port_one_pad_oe_out(p1_oe),
    .port_two_pad_in(p2_pin), .port_two_pad_out(p2_drv), .port_two_pad_oe_out(p2_oe),
    .timer_channel0_output_in(mod_sig[0]), .timer_channel1_output_in(mod_sig[1]),
    .timer_channel2_output_in(mod_sig[2]), .submain_system_clock_in(mod_sig[3]),
    .auxiliary_clock_in(mod_sig[4]), .comparator_result_out_in(mod_sig[5]),
    .timer_external_clock_in_out(to_mod[0]), .capture0_input_a_out(to_mod[1]),
    .capture1_input_a_out(to_mod[2]), .capture2_input_a_out(to_mod[3]),
    .timer_alternate_clock_in_out(to_mod[4]), .capture0_input_b_out(to_mod[5]),
    .irq_out
  );
  dpg_pin_partner partner (
    .clk_in, .rst_in, .ext_level_in(ext_lvl), .mod_level_in(mod_lvl),
    .p1_drive_in(p1_drv), .p1_oe_in(p1_oe), .p2_drive_in(p2_drv), .p2_oe_in(p2_oe),
    .p1_pin_out(p1_pin), .p2_pin_out(p2_pin), .mod_out(mod_sig)
  );
  always #25 clk_in = ~clk_in;
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // One APB transfer; returns {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    r = {pslverr_out, prdata_out};
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  function automatic logic [11:0] ad(input int p, input int g);
    return {6'h00, p[0], g[2:0], 2'b00};
  endfunction : ad
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [32:0] r;
    apb(1'b1, a, {24'h000000, d}, r);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h00000000, r);
    `CHK(nm, e, r)
  endtask : rd
  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [7:0] pat;
    tick(8);
    rst_in <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      for (int g = 0; g < 8; g++) begin
        rd("reset value", ad(p, g), 33'h000000000);
      end
      for (int g = 1; g < 7; g++) begin
        if (g != `DPG_REG_IFG) begin
          pat = 8'hc3 ^ 8'(g * 17 + p * 32);
          wr(ad(p, g), pat);
          rd("readback", ad(p, g), {25'h0000000, pat});
          wr(ad(p, g), 8'h00);
        end
      end
    end
    rd("unmapped", 12'h040, {1'b1, 32'h00000000});
    rd("unaligned", 12'h002, {1'b1, 32'h00000000});
    wr(ad(`DPG_P1, `DPG_REG_OUT), 8'hff);
    wr(ad(`DPG_P2, `DPG_REG_OUT), 8'hff);
    wr(ad(`DPG_P1, `DPG_REG_DIR), 8'h5a);
    wr(ad(`DPG_P2, `DPG_REG_DIR), 8'h1b);
    tick(3);
    `CHK("p1 oe", 8'h5a, p1_oe)
    `CHK("p2 oe", 6'h1b, p2_oe)
    `CHK("p1 gpio", 8'hff, p1_drv)
    `CHK("p2 gpio", 6'h3f, p2_drv)
    wr(ad(`DPG_P1, `DPG_REG_SEL), 8'hff);
    wr(ad(`DPG_P2, `DPG_REG_SEL), 8'hff);
    for (int i = 0; i < 2; i++) begin
      mod_lvl <= i ? 6'h15 : 6'h2a;
      tick(4);
      `CHK("p1 oe sel", 8'h5a, p1_oe)
      `CHK("p1 module", {mod_lvl[2:0], mod_lvl[3], mod_lvl[2:0], 1'b0}, p1_drv)
      `CHK("p2 module", {1'b0, mod_lvl[2:1], mod_lvl[5], 1'b0, mod_lvl[4]}, p2_drv)
    end
    wr(ad(`DPG_P1, `DPG_REG_DIR), 8'h00);
    wr(ad(`DPG_P2, `DPG_REG_DIR), 8'h00);
    for (int i = 0; i < 2; i++) begin
      ext_lvl <= i ? 14'h12a5 : 14'h2d5a;
      tick(5);
      `CHK("to modules", {ext_lvl[10:9], ext_lvl[3:0]}, to_mod)
      rd("p1 input", ad(`DPG_P1, `DPG_REG_IN), {25'h0000000, ext_lvl[7:0]});
      rd("p2 input", ad(`DPG_P2, `DPG_REG_IN), {27'h0000000, ext_lvl[13:8]});
    end
    wr(ad(`DPG_P1, `DPG_REG_SEL), 8'h00);
    wr(ad(`DPG_P2, `DPG_REG_SEL), 8'h00);
    tick(4);
    `CHK("gated inputs", 6'h00, to_mod)
    ext_lvl <= 14'h0000;
    wr(ad(`DPG_P1, `DPG_REG_IES), 8'h02);
    wr(ad(`DPG_P1, `DPG_REG_IE), 8'h01);
    wr(ad(`DPG_P2, `DPG_REG_IE), 8'hc0);
    wr(ad(`DPG_P1, `DPG_REG_IFG), 8'hff);
    wr(ad(`DPG_P2, `DPG_REG_IFG), 8'hff);
    tick(3);
    `CHK("irq idle", 1'b0, irq_out)
    ext_lvl <= 14'h0003;
    tick(6);
    rd("rise flag", ad(`DPG_P1, `DPG_REG_IFG), 33'h000000001);
    `CHK("irq on", 1'b1, irq_out)
    wr(ad(`DPG_P1, `DPG_REG_IFG), 8'h01);
    tick(3);
    `CHK("irq off", 1'b0, irq_out)
    ext_lvl <= 14'h0001;
    tick(6);
    rd("fall flag", ad(`DPG_P1, `DPG_REG_IFG), 33'h000000002);
    `CHK("irq masked", 1'b0, irq_out)
    wr(ad(`DPG_P2, `DPG_REG_SET), 8'h80);
    tick(3);
    rd("sw flag", ad(`DPG_P2, `DPG_REG_IFG), 33'h000000080);
    `CHK("sw irq", 1'b1, irq_out)
    rd("set reads 0", ad(`DPG_P2, `DPG_REG_SET), 33'h000000000);
    wr(ad(`DPG_P2, `DPG_REG_IFG), 8'h80);
    tick(3);
    `CHK("sw irq off", 1'b0, irq_out)
    ext_lvl <= 14'h0000;
    tick(4);
    ce_lvl  <= 1'b0;
    ext_lvl <= 14'h0001;
    tick(6);
    `CHK("frozen irq", 1'b0, irq_out)
    ce_lvl <= 1'b1;
    tick(6);
    `CHK("resumed irq", 1'b1, irq_out)
    wrap_up();
  end
endmodule : dpg_ports_tb
